// File: logic/mat_bridge.sv
// Purpose: single-transfer bridge handling each transfer by its memory type
// Assumes: both bus sides on ref_clk, srst synchronous active high
// Notes: one transfer in flight, plus one posted non-shareable Normal write
//
// Functional notes
// RQ1: prot[6:2] selects memory type; others illegal
// RQ2: device reads always return downstream data
// RQ3: device transfers never split, combined or merged
// RQ4: device reads issued only on manager request
// RQ5: device transfers keep their original order
// RQ6: device transfer size passes unchanged
// RQ7: bursts may split, beat count kept
// RQ8: device prot only loses bufferable bit
// RQ9: device-nE write answered after destination answers
// RQ10: device-E early answer needs global visibility
// RQ11: normal memory may speculate or merge writes
// RQ12: normal memory may change burst and size
// RQ13: normal overlapping transfers stay ordered
// RQ14: shareable normal answered only once visible
// RQ15: non-cacheable writes drain promptly downstream
// RQ16: non-cacheable read data never kept
// RQ17: write-through looked up, writes drain promptly
// RQ18: write-back looked up, may hold writes
// RQ19: allocate hint follows prot[5]
// RQ20: legacy four bits widen to seven
// RQ21: upper prot bits may be dropped downstream
// RQ22: nonsec high means non-secure transfer
// RQ23: nonsec steady across a burst
// RQ24: nonsec forwarded with every issued transfer
`timescale 1ns/100ps
// shared offsets and codes; the guard keeps a second inclusion harmless
`include "mat_defs.svh"
module mat_bridge #(
  parameter int AW      = 32,    // address width
  parameter int DW      = 32,    // data width
  parameter bit LEGACY4 = 1'b0,  // upstream carries only prot[3:0]
  parameter bit DEV_NB  = 1'b0,  // clear bufferable on device transfers
  parameter bit POST_EN = 1'b1   // allow early answers on non-shareable normal writes
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                hsel,
  input  wire logic [AW-1:0]       haddr,
  input  wire mat_pkg::mat_trans_t htrans,
  input  wire logic                hwrite,
  input  wire mat_pkg::mat_size_t  hsize,
  input  wire mat_pkg::mat_prot_t  hprot,
  input  wire logic                hnonsec,
  input  wire logic [DW-1:0]       hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [DW-1:0]            hrdata,
  output logic [AW-1:0]            m_haddr,
  output mat_pkg::mat_trans_t      m_htrans,
  output logic                     m_hwrite,
  output mat_pkg::mat_size_t       m_hsize,
  output mat_pkg::mat_burst_t      m_hburst,
  output mat_pkg::mat_prot_t       m_hprot,
  output logic                     m_hnonsec,
  output logic [DW-1:0]            m_hwdata,
  input  wire logic                m_hready,
  input  wire logic [DW-1:0]       m_hrdata,
  input  wire logic                m_hresp,
  output logic                     cache_lookup,
  output logic                     cache_alloc,
  output logic                     post_err
);
  import mat_pkg::*;

  // refuse widths the byte-lane and 1KB decode logic cannot serve
  if (AW < 10 || DW < 8 || (DW % 8) != 0) begin : g_bad_width
    $error("mat_bridge: unsupported AW or DW");
  end

  // all state of the bridge
  typedef struct packed {
    mat_state_e      fsm;      // control state
    logic            rdy;      // upstream ready
    logic            resp;     // upstream error response
    logic [DW-1:0]   rdata;    // upstream read data
    logic            pend;     // transfer captured behind a posted write
    logic [AW-1:0]   c_addr;   // captured address
    logic            c_write;  // captured direction
    mat_size_t       c_size;   // captured size
    mat_prot_t       c_prot;   // captured, widened protection
    logic            c_nonsec; // captured security
    mat_mem_e        c_mem;    // captured memory type
    logic [AW-1:0]   m_addr;   // downstream address
    mat_trans_t      m_trans;  // downstream transfer type
    logic            m_write;  // downstream direction
    mat_size_t       m_size;   // downstream size
    mat_prot_t       m_prot;   // downstream protection
    logic            m_nonsec; // downstream security
    logic [DW-1:0]   m_wdata;  // downstream write data
    logic            lookup;   // cache lookup required
    logic            alloc;    // allocate hint
    logic            perr;     // posted write came back with error
  } mat_regs_s;

  mat_regs_s  state_r;   // registered state
  mat_regs_s  state_nxt; // next state
  mat_prot_t  in_prot;   // upstream prot, widened when legacy
  mat_mem_e   in_mem;    // upstream memory type
  logic       take;      // upstream address phase accepted
  logic       can_take;  // state accepts a new address
  logic       iss;       // start a downstream address phase
  logic       iss_in;    // issue straight from upstream inputs
  logic       post_ok;   // current write may be answered early
  mat_mem_e   s_mem;     // issue source memory type
  mat_prot_t  s_prot;    // issue source protection

  // legacy components only have four prot bits
  assign in_prot  = LEGACY4 ? mat_legacy(hprot[3:0]) : hprot; // [RQ20]
  assign in_mem   = mat_decode(in_prot); // [RQ1]
  // nonsec is sampled with the address phase only, steady in a burst
  assign take     = hsel & hready & htrans[1]; // [RQ23]
  assign can_take = (state_r.fsm == S_IDLE) || (state_r.fsm == S_ERR2) ||
                    (state_r.fsm == S_POST && !state_r.pend);
  // early answer only where nobody else can observe the difference
  assign post_ok  = POST_EN && state_r.c_write && !state_r.c_prot[`MAT_PROT_SHR] &&
                    (state_r.c_mem == MEM_NC || state_r.c_mem == MEM_WT ||
                     state_r.c_mem == MEM_WB); // [RQ10] [RQ14] [RQ11]
  // issue source is picked inside the next-state process, no loop through iss_in

  // next-state logic
  always_comb begin
    state_nxt      = state_r;
    state_nxt.perr = 1'b0;
    iss            = 1'b0;
    iss_in         = 1'b0;
    s_mem          = state_r.c_mem;
    s_prot         = state_r.c_prot;
    case (state_r.fsm)
      // idle or second error cycle: ready, accept an address
      S_IDLE, S_ERR2: begin
        state_nxt.rdy  = 1'b1;
        state_nxt.resp = 1'b0;
        state_nxt.fsm  = S_IDLE;
        if (take) begin
          state_nxt.rdy = 1'b0;
          if (in_mem == MEM_ILLEGAL) begin
            state_nxt.resp = 1'b1; // [RQ1]
            state_nxt.fsm  = S_ERR1;
          end else begin
            iss    = 1'b1; // [RQ4]
            iss_in = 1'b1;
          end
        end
      end
      // downstream address phase, held until accepted
      S_DADDR: begin
        if (m_hready) begin
          state_nxt.m_trans = `MAT_TRANS_IDLE;
          state_nxt.m_wdata = hwdata;
          if (post_ok) begin
            state_nxt.rdy = 1'b1; // [RQ18]
            state_nxt.fsm = S_POST;
          end else begin
            state_nxt.fsm = S_DDATA;
          end
        end
      end
      // downstream data phase, upstream stalled until destination answers
      S_DDATA: begin
        if (m_hready) begin
          if (m_hresp) begin
            state_nxt.resp = 1'b1;
            state_nxt.fsm  = S_ERR1;
          end else begin
            state_nxt.rdy = 1'b1; // [RQ9]
            state_nxt.fsm = S_IDLE;
          end
          // read data comes from the destination only, never replayed
          if (!state_r.c_write) begin
            state_nxt.rdata = m_hrdata; // [RQ2] [RQ16]
          end
        end
      end
      // posted write draining at once; later transfer waits behind it
      S_POST: begin
        if (m_hready) begin
          state_nxt.perr = m_hresp; // [RQ15] [RQ17]
          state_nxt.pend = 1'b0;
          state_nxt.fsm  = S_IDLE;
          if (take) begin
            state_nxt.rdy = 1'b0;
            if (in_mem == MEM_ILLEGAL) begin
              state_nxt.resp = 1'b1;
              state_nxt.fsm  = S_ERR1;
            end else begin
              iss    = 1'b1;
              iss_in = 1'b1;
            end
          end else if (state_r.pend) begin
            // an illegal transfer held behind the post is refused only now
            if (state_r.c_mem == MEM_ILLEGAL) begin
              state_nxt.resp = 1'b1;
              state_nxt.fsm  = S_ERR1;
            end else begin
              iss = 1'b1; // [RQ5] [RQ13]
            end
          end
        end else if (take) begin
          // keep order: hold the new transfer until the write is out
          state_nxt.pend = 1'b1; // [RQ5] [RQ13]
          state_nxt.rdy  = 1'b0;
        end
      end
      // first error cycle: second one follows with ready high
      S_ERR1: begin
        state_nxt.resp = 1'b1;
        state_nxt.rdy  = 1'b1;
        state_nxt.fsm  = S_ERR2;
      end
      default: begin
        state_nxt.fsm = S_IDLE;
      end
    endcase
    // capture every accepted address phase
    if (take && can_take) begin
      state_nxt.c_addr   = haddr;
      state_nxt.c_write  = hwrite;
      state_nxt.c_size   = hsize;
      state_nxt.c_prot   = in_prot;
      state_nxt.c_nonsec = hnonsec;
      state_nxt.c_mem    = in_mem;
    end
    // one beat per upstream beat, as a single: no split, no merge
    if (iss) begin
      s_mem              = iss_in ? in_mem : state_r.c_mem;
      s_prot             = iss_in ? in_prot : state_r.c_prot;
      state_nxt.fsm      = S_DADDR;
      state_nxt.m_trans  = `MAT_TRANS_NSEQ; // [RQ3] [RQ7]
      state_nxt.m_addr   = iss_in ? haddr : state_r.c_addr;
      state_nxt.m_write  = iss_in ? hwrite : state_r.c_write;
      state_nxt.m_size   = iss_in ? hsize : state_r.c_size; // [RQ6]
      state_nxt.m_nonsec = iss_in ? hnonsec : state_r.c_nonsec; // [RQ24] [RQ22]
      state_nxt.m_prot   = s_prot; // [RQ8]
      if (DEV_NB && (s_mem == MEM_DEV_NE || s_mem == MEM_DEV_E)) begin
        state_nxt.m_prot[`MAT_PROT_BUF] = 1'b0; // [RQ8]
      end
      state_nxt.lookup = (s_mem == MEM_WT) || (s_mem == MEM_WB); // [RQ17] [RQ18]
      state_nxt.alloc  = ((s_mem == MEM_WT) || (s_mem == MEM_WB)) &&
                         s_prot[`MAT_PROT_ALC]; // [RQ19]
    end
  end

  // state register
  // only ready leaves reset high, so the bus may start at once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r      <= '0;
      state_r.rdy  <= `MAT_RST_READY;
      state_r.resp <= `MAT_RST_RESP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register, except the tied-off burst code
  assign hreadyout    = state_r.rdy;
  assign hresp        = state_r.resp;
  assign hrdata       = state_r.rdata;
  assign m_haddr      = state_r.m_addr;
  assign m_htrans     = state_r.m_trans;
  assign m_hwrite     = state_r.m_write;
  assign m_hsize      = state_r.m_size;
  // tie-off: every forwarded beat is a single, so the code never moves
  assign m_hburst     = `MAT_BURST_SINGLE; // [RQ12] [RQ7]
  assign m_hprot      = state_r.m_prot; // a four-bit sink takes [3:0] [RQ21]
  assign m_hnonsec    = state_r.m_nonsec;
  assign m_hwdata     = state_r.m_wdata;
  assign cache_lookup = state_r.lookup;
  assign cache_alloc  = state_r.alloc;
  assign post_err     = state_r.perr;

  // checking helpers: legal takes not yet issued downstream
  // a downstream beat with nothing outstanding was never requested
  logic [1:0] outst_r;  // outstanding count
  logic       m_acc;    // downstream address accepted
  logic       take_ok;  // legal transfer accepted
  assign m_acc   = (state_r.m_trans == `MAT_TRANS_NSEQ) && m_hready;
  assign take_ok = take && can_take && (in_mem != MEM_ILLEGAL);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outst_r <= 2'h0;
    end else if (take_ok && !m_acc) begin
      outst_r <= outst_r + 2'h1;
    end else if (!take_ok && m_acc) begin
      outst_r <= outst_r - 2'h1;
    end
  end

  // assertions run on the bridge clock and sleep while reset is high
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_issue_count: assert property (!(m_acc && outst_r == 2'h0)) // [RQ4] [RQ3]
    else $error("downstream transfer without an upstream request");
  chk_single_beat: assert property ((m_htrans != `MAT_TRANS_SEQ) && // [RQ7]
    (m_hburst == `MAT_BURST_SINGLE))
    else $error("forwarded beat is not a single");
  chk_size_kept: assert property ((iss && iss_in) |=> // [RQ6]
    (m_hsize == $past(hsize)) && (m_htrans == `MAT_TRANS_NSEQ))
    else $error("forwarded size differs from request");
  chk_nonsec_fwd: assert property ((iss && iss_in) |=> // [RQ24]
    (m_hnonsec == $past(hnonsec)))
    else $error("security indication not forwarded");
  chk_prot_kept: assert property ((iss && iss_in && !LEGACY4) |=> // [RQ8]
    (m_hprot[6:3] == $past(hprot[6:3])) && (m_hprot[1:0] == $past(hprot[1:0])))
    else $error("protection bits altered");
  chk_ne_wait: assert property ((state_r.fsm == S_DDATA && !m_hready) |=> // [RQ9]
    !hreadyout)
    else $error("answer given before destination answered");
  chk_post_class: assert property ((state_r.fsm == S_POST && !state_r.pend) |-> // [RQ14] [RQ10]
    (!state_r.c_prot[`MAT_PROT_SHR] && state_r.c_mem != MEM_DEV_NE &&
     state_r.c_mem != MEM_DEV_E))
    else $error("early answer on shareable or device write");
  chk_read_source: assert property ((state_r.fsm == S_DDATA && m_hready && // [RQ2]
    !m_hresp && !state_r.c_write) |=> (hreadyout && hrdata == $past(m_hrdata)))
    else $error("read data not from destination");
  chk_illegal_err: assert property ((state_r.fsm == S_IDLE && take && // [RQ1]
    in_mem == MEM_ILLEGAL) |=> (hresp && !hreadyout) ##1 (hresp && hreadyout))
    else $error("illegal attributes not answered with error");
  chk_pend_order: assert property ((state_r.fsm == S_POST && state_r.pend) |-> // [RQ5]
    (m_htrans == `MAT_TRANS_IDLE))
    else $error("transfer overtook a posted write");

  // a taken transfer behind a draining post stalls upstream and stays off the bus
  chk_pend_hold: assert property ((state_r.fsm == S_POST && // [RQ5] [RQ13]
    !m_hready && take) |=> (!hreadyout && m_htrans == `MAT_TRANS_IDLE))
    else $error("transfer not held behind a posted write");
  // cache hints follow the lookup and allocate bits of the request
  chk_cache_hint: assert property ((iss && iss_in && !LEGACY4) |=> // [RQ17] [RQ19]
    (cache_lookup == $past(hprot[`MAT_PROT_LKP])) &&
    (cache_alloc == $past(hprot[`MAT_PROT_LKP] & hprot[`MAT_PROT_ALC])))
    else $error("cache hints differ from request");
  // an error answer always gets its second cycle with ready high
  chk_err_second: assert property ((hresp && !hreadyout) |=> // [RQ1]
    (hresp && hreadyout))
    else $error("error answer missing its second cycle");
  // a drained post reports its downstream error for exactly one cycle, the next one
  chk_post_drain: assert property ((state_r.fsm == S_POST && m_hready) |=> // [RQ15]
    (post_err == $past(m_hresp)))
    else $error("posted write error not reported");

endmodule // mat_bridge

// File: logic/mat_defs.svh
// Purpose: shared constants of the memory attribute transfer bridge
// Assumes: included by the package and by the bridge module
// Notes: definitions only, guarded against double inclusion
`ifndef MAT_DEFS_SVH
`define MAT_DEFS_SVH
// transfer type codes
`define MAT_TRANS_IDLE   2'h0
`define MAT_TRANS_BUSY   2'h1
`define MAT_TRANS_NSEQ   2'h2
`define MAT_TRANS_SEQ    2'h3
// burst code used on every forwarded transfer
`define MAT_BURST_SINGLE 3'h0
// protection bit positions
`define MAT_PROT_BUF     2
`define MAT_PROT_MOD     3
`define MAT_PROT_LKP     4
`define MAT_PROT_ALC     5
`define MAT_PROT_SHR     6
// memory type encodings on prot[6:2], prot[5:2] (normal non-cacheable) or prot[4:2] (write-through, write-back)
`define MAT_ENC_DEV_NE   5'h00
`define MAT_ENC_DEV_E    5'h01
`define MAT_ENC_NC       4'h2
`define MAT_ENC_WT       3'h6
`define MAT_ENC_WB       3'h7
// reset values
`define MAT_RST_READY    1'h1
`define MAT_RST_RESP     1'h0
`endif

// File: logic/mat_pkg.sv
// Purpose: types and decode helpers of the memory attribute transfer bridge
// Assumes: mat_defs.svh on the include path
// Notes: memory type decode and legacy protection widening live here
package mat_pkg;
  `include "mat_defs.svh"
  typedef logic [1:0] mat_trans_t;   // transfer type
  typedef logic [2:0] mat_size_t;    // transfer size
  typedef logic [2:0] mat_burst_t;   // burst type
  typedef logic [6:0] mat_prot_t;    // protection attributes
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DADDR = 3'b001,
    S_DDATA = 3'b010,
    S_POST  = 3'b011,
    S_ERR1  = 3'b100,
    S_ERR2  = 3'b101
  } mat_state_e;
  typedef enum logic [2:0] {
    MEM_DEV_NE  = 3'b000,
    MEM_DEV_E   = 3'b001,
    MEM_NC      = 3'b010,
    MEM_WT      = 3'b011,
    MEM_WB      = 3'b100,
    MEM_ILLEGAL = 3'b111
  } mat_mem_e;
  // memory type from prot[6:2]; unlisted combinations are illegal
  function automatic mat_mem_e mat_decode(input mat_prot_t p);
    if (p[6:2] == `MAT_ENC_DEV_NE) return MEM_DEV_NE;
    if (p[6:2] == `MAT_ENC_DEV_E) return MEM_DEV_E;
    if (p[5:2] == `MAT_ENC_NC) return MEM_NC;
    if (p[4:2] == `MAT_ENC_WT) return MEM_WT;
    if (p[4:2] == `MAT_ENC_WB) return MEM_WB;
    return MEM_ILLEGAL;
  endfunction
  // widen four protection bits: [3] feeds 6,4,3 and [2] stays
  function automatic mat_prot_t mat_legacy(input logic [3:0] p);
    return {p[3], 1'b0, p[3], p[3], p[2], p[1:0]};
  endfunction
endpackage

// File: verif/mat_sub_model.sv
// Purpose: downstream subordinate model, the final destination of bridged transfers
// Assumes: one clock; bridge drives the manager side with single transfers
// Notes: address bit 6 set answers error; read data toggles outside a read answer
`timescale 1ns/100ps
module mat_sub_model (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [31:0] m_haddr,
  input  wire logic [1:0]  m_htrans,
  input  wire logic        m_hwrite,
  input  wire logic [31:0] m_hwdata,
  output logic             m_hready,
  output logic [31:0]      m_hrdata,
  output logic             m_hresp,
  output int               wr_cnt
);
  logic [31:0] mem [0:15];  // destination storage, word indexed
  logic        ph_r;        // data phase in progress
  logic        wr_r;        // data phase is a write
  logic        er_r;        // data phase answers error
  logic [3:0]  idx_r;       // word index of the data phase
  int          wc_r;        // wait cycles left
  logic [31:0] noise_r;     // keeps stale read data from looking valid
  // error answer takes the last two cycles, ready high in the second
  assign m_hready = !ph_r || wc_r == 0;
  assign m_hresp  = ph_r && er_r && wc_r <= 1;
  assign m_hrdata = (ph_r && !wr_r && !er_r && wc_r == 0) ? mem[idx_r] : noise_r;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = i * 32'h0101_0101;
  end
  // address sampled only when ready; zero to two random wait cycles on each data phase
  always @(posedge ref_clk) begin
    noise_r <= {noise_r[30:0], ~noise_r[31]};
    if (srst) begin
      ph_r    <= 1'b0;
      wc_r    <= 0;
      wr_cnt  <= 0;
      noise_r <= 32'h5a5a_a5a5;
    end else if (ph_r && wc_r != 0) begin
      wc_r <= wc_r - 1;
    end else begin
      if (ph_r && wr_r && !er_r) begin
        mem[idx_r] <= m_hwdata;
        wr_cnt     <= wr_cnt + 1;
      end
      ph_r  <= m_htrans[1];
      wr_r  <= m_hwrite;
      er_r  <= m_haddr[6];
      idx_r <= m_haddr[5:2];
      wc_r  <= m_haddr[6] ? 1 + $urandom % 2 : $urandom % 3;
    end
  end
endmodule // mat_sub_model

// File: verif/testbench.sv
// Purpose: self-checking bench of the memory attribute bridge
// Assumes: default parameters; partner model stands downstream
// Notes: pipelined upstream manager; model memory mirrors the destination
`timescale 1ns/100ps
`include "mat_defs.svh"
module testbench;
  import mat_pkg::*;
  typedef logic [75:0] mat_tbx_t;  // addr, write, size, prot, nonsec, wdata
  logic        ref_clk, srst, hsel, hwrite, hnonsec, hready, hreadyout, hresp;
  logic        m_hwrite, m_hnonsec, m_hready, m_hresp, cache_lookup, cache_alloc, post_err;
  logic [31:0] haddr, hwdata, hrdata, m_haddr, m_hwdata, m_hrdata;
  mat_trans_t  htrans, m_htrans;
  mat_size_t   hsize, m_hsize;
  mat_prot_t   hprot, m_hprot;
  mat_burst_t  m_hburst;
  int          err_total, compares, wr_exp, post_exp, post_seen;
  logic [31:0] bmem [16];          // expected destination contents
  mat_tbx_t    xq [$];             // transfers still to present
  logic [63:0] iss_q [$];          // expected downstream issues
  logic [4:0]  enc [10] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h0f, 5'h12, 5'h1e, 5'h17,
                            5'h10, 5'h08};  // eight legal, two illegal
  logic [3:0]  lmap [4] = '{4'h0, 4'h1, 4'he, 4'hf};  // bits 6,4,3,2 per legacy code
  assign hready = hreadyout;       // single subordinate on the bus
  mat_bridge u_dut (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hnonsec(hnonsec),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite),
    .m_hsize(m_hsize), .m_hburst(m_hburst), .m_hprot(m_hprot), .m_hnonsec(m_hnonsec),
    .m_hwdata(m_hwdata), .m_hready(m_hready), .m_hrdata(m_hrdata), .m_hresp(m_hresp),
    .cache_lookup(cache_lookup), .cache_alloc(cache_alloc), .post_err(post_err));
  mat_sub_model u_sub (.ref_clk(ref_clk), .srst(srst), .m_haddr(m_haddr),
    .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hwdata(m_hwdata), .m_hready(m_hready),
    .m_hrdata(m_hrdata), .m_hresp(m_hresp), .wr_cnt());
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // memory type from prot[6:2], 7 for a combination not permitted
  function automatic int mtype(input logic [6:0] p);
    if (p[6:2] == 5'h00) return 0;
    if (p[6:2] == 5'h01) return 1;
    if (p[5:2] == 4'h2) return 2;
    if (p[4:3] == 2'h3) return p[2] ? 4 : 3;
    return 7;
  endfunction
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // judge one completed upstream transfer against the model
  task automatic check_done(input mat_tbx_t x);
    int t;
    bit pst;
    t   = mtype(x[39:33]);
    pst = x[43] && t inside {2, 3, 4} && !x[39];
    cmp("hresp", t == 7 || (x[50] && !pst), hresp);
    if (t != 7 && x[50] && pst) post_exp++;
    if (t != 7 && !x[50] && x[43]) begin
      bmem[x[49:46]] = x[31:0];
      wr_exp++;
      if (!pst) cmp("writes landed", wr_exp, u_sub.wr_cnt);
    end
    if (t != 7 && !x[50] && !x[43]) cmp("hrdata", bmem[x[49:46]], hrdata);
  endtask
  // pipelined manager: next address rides the data phase of the previous one
  task automatic run_seq(input string name);
    mat_tbx_t cur, prv;
    bit       cv, pv;
    int       n, t;
    pv  = 0;
    prv = '0;
    do begin
      cv = xq.size() != 0;
      if (cv) cur = xq.pop_front();
      t = mtype(cur[39:33]);
      if (cv && t != 7) iss_q.push_back({cur[75:32], `MAT_BURST_SINGLE, t > 2, t > 2 && cur[38]});
      {haddr, hwrite, hsize, hprot, hnonsec} = cur[75:32];
      htrans = cv ? `MAT_TRANS_NSEQ : `MAT_TRANS_IDLE;
      hsel   = cv;
      hwdata = prv[31:0];
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (hreadyout !== 1'b1 && n < 300);
      if (n >= 300) cmp("ready wait", 0, 1);
      if (pv) check_done(prv);
      prv = cur;
      pv  = cv;
      #1;
    end while (pv || xq.size() != 0);
    $display("test %s done", name);
  endtask
  task automatic add(input logic [31:0] a, input logic w, input logic [2:0] s,
                     input logic [6:0] p, input logic ns, input logic [31:0] d);
    xq.push_back({a, w, s, p, ns, d});
  endtask
  // every downstream issue must match the next expected one, whole and in order
  always @(posedge ref_clk) begin
    if (post_err === 1'b1) post_seen++;
    if (!srst && m_htrans == `MAT_TRANS_NSEQ && m_hready) begin
      if (iss_q.size() == 0) cmp("unrequested issue", 0, 1);
      else cmp("issue", iss_q.pop_front(), {m_haddr, m_hwrite, m_hsize, m_hprot,
        m_hnonsec, m_hburst, cache_lookup, cache_alloc});
    end
  end
  initial begin
    #400_000;
    err_total++;
    wrap_up();
  end
  initial begin
    {srst, hsel, haddr, htrans, hwrite, hsize, hprot, hnonsec, hwdata} = '0;
    srst = 1'b1;
    {err_total, compares, wr_exp, post_exp, post_seen} = '0;
    for (int i = 0; i < 16; i++) bmem[i] = i * 32'h0101_0101;
    void'($urandom(32'he90b));
    repeat (6) @(posedge ref_clk);
    #1 srst = 1'b0;
    // first request only once the bridge has seen reset low at one edge
    @(posedge ref_clk);
    #1;
    // each memory type, write then read back, both security states
    for (int i = 0; i < 10; i++) begin
      add(i * 4, 1'b1, 3'h2, {enc[i], 2'h3}, i[0], $urandom);
      add(i * 4, 1'b0, 3'h2, {enc[i], 2'h1}, ~i[0], 32'h0000_0000);
    end
    run_seq("memory types");
    // random back-to-back mix with downstream errors and illegal types
    for (int i = 0; i < 160; i++)
      add({25'h0, $urandom % 4 == 0, 4'($urandom), 2'h0}, 1'($urandom), 3'($urandom % 3),
          ($urandom % 4 != 0) ? {enc[$urandom % 10], 2'($urandom)} : 7'($urandom),
          1'($urandom), $urandom);
    run_seq("random mix");
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) cmp("destination", bmem[i], u_sub.mem[i]);
    // four-bit protection widening, table value per code of bits 3:2
    for (int i = 0; i < 16; i++)
      cmp("legacy prot", {lmap[i / 4][3], 1'b0, lmap[i / 4][2:0], 2'(i)},
          mat_legacy(4'(i)));
    cmp("posted errors", post_exp, post_seen);
    cmp("issues left", 0, iss_q.size());
    $display("test final state done");
    wrap_up();
  end
endmodule // testbench
